// ==== inc/stop_brake_pkg.sv ====
// shared constants and types of the stop-mode selector and brake sequencer
// assumes a 25 MHz control clock and a word-addressed plain register port
package stop_brake_pkg;

    // register indices on the plain port
    localparam logic [3:0] OFS_FAULT2_STOP = 4'h0;
    localparam logic [3:0] OFS_OVERTRAVEL_STOP = 4'h1;
    localparam logic [3:0] OFS_FAULT1_STOP = 4'h2;
    localparam logic [3:0] OFS_BRAKE_ON_DELAY = 4'h3;
    localparam logic [3:0] OFS_BRAKE_OFF_DELAY = 4'h4;
    localparam logic [3:0] OFS_SPEED_THRESHOLD = 4'h5;
    localparam logic [3:0] OFS_SERVO_OFF_DELAY = 4'h6;
    localparam logic [3:0] OFS_CONTROL = 4'h7;
    localparam logic [3:0] OFS_STATUS = 4'h8;

    // reset values
    localparam logic [15:0] RST_FAULT2_STOP = 16'h0002;
    localparam logic [15:0] RST_OVERTRAVEL_STOP = 16'h0001;
    localparam logic [15:0] RST_FAULT1_STOP = 16'h0002;
    localparam logic [15:0] RST_BRAKE_ON_DELAY = 16'h00FA;
    localparam logic [15:0] RST_BRAKE_OFF_DELAY = 16'h0096;
    localparam logic [15:0] RST_SPEED_THRESHOLD = 16'h001E;
    localparam logic [15:0] RST_SERVO_OFF_DELAY = 16'h01F4;
    localparam logic [15:0] RST_CONTROL = 16'h0000;

    // accepted ranges of written values
    localparam int FAULT2_MIN = -5;
    localparam int FAULT2_MAX = 3;
    localparam int FAULT2_MAX_EXT = 4;
    localparam logic [15:0] OVERTRAVEL_MAX = 16'h0007;
    localparam logic [15:0] FAULT1_MAX = 16'h0002;
    localparam logic [15:0] BRAKE_ON_MAX = 16'h01F4;
    localparam logic [15:0] BRAKE_OFF_MIN = 16'h0032;
    localparam logic [15:0] BRAKE_OFF_MAX = 16'h03E8;
    localparam logic [15:0] SPEED_MIN = 16'h0014;
    localparam logic [15:0] SPEED_MAX = 16'h0BB8;
    localparam logic [15:0] SERVO_OFF_MIN = 16'h0001;
    localparam logic [15:0] SERVO_OFF_MAX = 16'h03E8;

    // control register fields
    localparam int CTL_BRAKE_FUNC_BIT = 0;
    localparam int CTL_PRIORITY_BIT = 2;
    localparam logic [15:0] CTL_WRITE_MASK = 16'h0005;

    // timing
    localparam int CLOCK_PERIOD_NS = 40;
    localparam int MILLISECOND_NS = 1000000;
    localparam int CYCLES_PER_MS = MILLISECOND_NS / CLOCK_PERIOD_NS;

    typedef enum logic [2:0] {
        DEC_NONE = 3'h0,
        DEC_COAST = 3'h1,
        DEC_DB = 3'h2,
        DEC_ZERO_SPEED = 3'h3,
        DEC_ETORQUE = 3'h4,
        DEC_RAMP_PROFILE = 3'h5,
        DEC_RAMP_QUICK = 3'h6
    } decel_t;

    typedef enum logic [1:0] {
        POST_DEENERGIZE = 2'h0,
        POST_DB = 2'h1,
        POST_LOCK = 2'h2
    } post_t;

    typedef enum logic [2:0] {
        CAUSE_NONE = 3'h0,
        CAUSE_FAULT1 = 3'h1,
        CAUSE_FAULT2 = 3'h2,
        CAUSE_OVERTRAVEL = 3'h3,
        CAUSE_SERVO_OFF = 3'h4
    } cause_t;

    typedef struct packed {
        logic active;
        decel_t decel;
        post_t post;
    } stop_plan_t;

endpackage

// ==== inc/ms_tick_if.sv ====
// carries the millisecond enable from the divider to the sequencer
// assumes both ends share the one control clock
`timescale 1ns/100ps
interface ms_tick_if;
    logic tick;
    modport source (output tick);
    modport sink (input tick);
endinterface

// ==== logic/ms_tick_divider.sv ====
// millisecond enable divider
// assumes a synchronised active-low reset from the top module
`timescale 1ns/100ps
module ms_tick_divider #(
    parameter int CYCLES = 25000
) (
    input wire logic clk,
    input wire logic rst_n,
    ms_tick_if.source tick_out
);
    initial begin
        if (CYCLES < 2 || CYCLES > 65536) begin
            $error("ms_tick_divider: CYCLES out of range");
        end
    end

    logic [15:0] count_reg;
    logic [15:0] count_next;
    logic tick_reg;
    logic tick_next;

    always_comb begin
        tick_next = (count_reg == 16'(CYCLES - 1));
        count_next = tick_next ? 16'h0000 : count_reg + 16'h0001;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
            tick_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            tick_reg <= tick_next;
        end
    end

    assign tick_out.tick = tick_reg;
endmodule

// ==== logic/servo_stop_brake_sequencer.sv ====
// stop-mode selector and holding-brake sequencer of a servo drive
// assumes synchronous inputs and a software master on the plain register port
`timescale 1ns/100ps
module servo_stop_brake_sequencer
    import stop_brake_pkg::*;
#(
    parameter bit EXTENDED_VARIANT = 1'b0,
    parameter bit NO_DYNAMIC_BRAKE_VARIANT = 1'b0,
    parameter int MS_CYCLES = CYCLES_PER_MS
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    input wire logic servo_enable,
    input wire logic fault1_active,
    input wire logic fault2_active,
    input wire logic overtravel_active,
    input wire logic motor_at_standstill,
    input wire logic [15:0] motor_speed_rpm,
    output logic power_stage_enable,
    output logic dynamic_brake,
    output logic holding_brake_out,
    output logic reference_accept,
    output decel_t decel_mode,
    output post_t post_state
);
    initial begin
        if (MS_CYCLES < 2) begin
            $error("servo_stop_brake_sequencer: MS_CYCLES too small");
        end
    end

    typedef enum logic [2:0] {
        ST_OFF = 3'b000,
        ST_HOLD_REF = 3'b001,
        ST_RUN = 3'b011,
        ST_STOPPING = 3'b010,
        ST_BRAKE_WAIT = 3'b110,
        ST_STOPPED = 3'b111
    } state_t;

    ////////////////////////////////////////////////////////////////////////////
    // reset release and millisecond enable

    logic rst_meta_reg;
    logic rst_n;

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rst_meta_reg <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_reg <= 1'b1;
            rst_n <= rst_meta_reg;
        end
    end

    ms_tick_if ms_tick ();

    ms_tick_divider #(
        .CYCLES(MS_CYCLES)
    ) divider (
        .clk(clk),
        .rst_n(rst_n),
        .tick_out(ms_tick.source)
    );

    ////////////////////////////////////////////////////////////////////////////
    // stop code decoding

    function automatic stop_plan_t decode_stop(cause_t cause, logic [15:0] code, logic forced);
        stop_plan_t p;
        p = '{active: 1'b1, decel: DEC_RAMP_QUICK, post: POST_DEENERGIZE};
        unique case (cause)
            CAUSE_FAULT2: begin
                if (forced) begin
                    p = '{1'b1, DEC_RAMP_QUICK, POST_DEENERGIZE};
                end else begin
                    case (code)
                        16'hFFFB: p = '{1'b1, DEC_ZERO_SPEED, POST_DB};
                        16'hFFFC: p = '{1'b1, DEC_ETORQUE, POST_DB};
                        16'hFFFD: p = '{1'b1, DEC_RAMP_QUICK, POST_DB};
                        16'hFFFE: p = '{1'b1, DEC_RAMP_PROFILE, POST_DB};
                        16'hFFFF: p = '{1'b1, DEC_DB, POST_DB};
                        16'h0000: p = '{1'b1, DEC_COAST, POST_DEENERGIZE};
                        16'h0001: p = '{1'b1, DEC_RAMP_PROFILE, POST_DEENERGIZE};
                        16'h0002: p = '{1'b1, DEC_RAMP_QUICK, POST_DEENERGIZE};
                        16'h0003: p = '{1'b1, DEC_ETORQUE, POST_DEENERGIZE};
                        16'h0004: p = '{1'b1, DEC_DB, POST_DEENERGIZE};
                        default: p = '{1'b1, DEC_COAST, POST_DEENERGIZE};
                    endcase
                end
            end
            CAUSE_OVERTRAVEL: begin
                if (forced) begin
                    p = '{1'b1, DEC_RAMP_QUICK, POST_LOCK};
                end else begin
                    case (code)
                        16'h0000: p = '{1'b1, DEC_COAST, POST_DEENERGIZE};
                        16'h0001: p = '{1'b1, DEC_ZERO_SPEED, POST_LOCK};
                        16'h0002: p = '{1'b1, DEC_ZERO_SPEED, POST_DEENERGIZE};
                        16'h0003: p = '{1'b1, DEC_RAMP_QUICK, POST_DEENERGIZE};
                        16'h0004: p = '{1'b1, DEC_RAMP_QUICK, POST_LOCK};
                        16'h0005: p = '{1'b1, DEC_DB, POST_DEENERGIZE};
                        16'h0006: p = '{1'b1, DEC_DB, POST_DB};
                        default: p = '{1'b0, DEC_NONE, POST_DEENERGIZE};
                    endcase
                end
            end
            CAUSE_FAULT1: begin
                if (forced && NO_DYNAMIC_BRAKE_VARIANT) begin
                    p = '{1'b1, DEC_COAST, POST_DEENERGIZE};
                end else if (forced) begin
                    p = '{1'b1, DEC_DB, POST_DB};
                end else begin
                    case (code)
                        16'h0001: p = '{1'b1, DEC_DB, POST_DEENERGIZE};
                        16'h0002: p = '{1'b1, DEC_DB, POST_DB};
                        default: p = '{1'b1, DEC_COAST, POST_DEENERGIZE};
                    endcase
                end
            end
            CAUSE_SERVO_OFF: p = '{1'b1, DEC_RAMP_QUICK, POST_DEENERGIZE};
            CAUSE_NONE: p = '{1'b0, DEC_NONE, POST_DEENERGIZE};
        endcase
        return p;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // register file

    logic [15:0] f2_sel_reg, f2_sel_next, ot_sel_reg, ot_sel_next, f1_sel_reg, f1_sel_next;
    logic [15:0] f2_act_reg, f2_act_next, ot_act_reg, ot_act_next, f1_act_reg, f1_act_next;
    logic [15:0] on_delay_reg, on_delay_next, off_delay_reg, off_delay_next;
    logic [15:0] speed_thr_reg, speed_thr_next, soff_delay_reg, soff_delay_next;
    logic [15:0] control_reg, control_next, rdata_reg, rdata_next;
    logic [15:0] status_word;
    logic f2_ok;
    logic forced;

    // out-of-range writes are dropped so the decoders never see an illegal code
    assign f2_ok = $signed(reg_wdata) >= 16'(FAULT2_MIN)
        && $signed(reg_wdata) <= 16'(EXTENDED_VARIANT ? FAULT2_MAX_EXT : FAULT2_MAX);
    assign forced = control_reg[CTL_BRAKE_FUNC_BIT] && !control_reg[CTL_PRIORITY_BIT];

    always_comb begin
        f2_sel_next = f2_sel_reg;
        ot_sel_next = ot_sel_reg;
        f1_sel_next = f1_sel_reg;
        on_delay_next = on_delay_reg;
        off_delay_next = off_delay_reg;
        speed_thr_next = speed_thr_reg;
        soff_delay_next = soff_delay_reg;
        control_next = control_reg;
        if (reg_write) begin
            unique case (reg_addr)
                OFS_FAULT2_STOP: if (f2_ok) f2_sel_next = reg_wdata;
                OFS_OVERTRAVEL_STOP: if (reg_wdata <= OVERTRAVEL_MAX) ot_sel_next = reg_wdata;
                OFS_FAULT1_STOP: if (reg_wdata <= FAULT1_MAX) f1_sel_next = reg_wdata;
                OFS_BRAKE_ON_DELAY: if (reg_wdata <= BRAKE_ON_MAX) on_delay_next = reg_wdata;
                OFS_BRAKE_OFF_DELAY: begin
                    if (reg_wdata >= BRAKE_OFF_MIN && reg_wdata <= BRAKE_OFF_MAX) off_delay_next = reg_wdata;
                end
                OFS_SPEED_THRESHOLD: begin
                    if (reg_wdata >= SPEED_MIN && reg_wdata <= SPEED_MAX) speed_thr_next = reg_wdata;
                end
                OFS_SERVO_OFF_DELAY: begin
                    if (reg_wdata >= SERVO_OFF_MIN && reg_wdata <= SERVO_OFF_MAX) soff_delay_next = reg_wdata;
                end
                OFS_CONTROL: control_next = reg_wdata & CTL_WRITE_MASK;
                default: ;
            endcase
        end
        // a selection written in motion waits here until the next standstill
        f2_act_next = motor_at_standstill ? f2_sel_reg : f2_act_reg;
        ot_act_next = motor_at_standstill ? ot_sel_reg : ot_act_reg;
        f1_act_next = motor_at_standstill ? f1_sel_reg : f1_act_reg;
        rdata_next = 16'h0000;
        if (reg_read) begin
            unique case (reg_addr)
                OFS_FAULT2_STOP: rdata_next = f2_sel_reg;
                OFS_OVERTRAVEL_STOP: rdata_next = ot_sel_reg;
                OFS_FAULT1_STOP: rdata_next = f1_sel_reg;
                OFS_BRAKE_ON_DELAY: rdata_next = on_delay_reg;
                OFS_BRAKE_OFF_DELAY: rdata_next = off_delay_reg;
                OFS_SPEED_THRESHOLD: rdata_next = speed_thr_reg;
                OFS_SERVO_OFF_DELAY: rdata_next = soff_delay_reg;
                OFS_CONTROL: rdata_next = control_reg;
                OFS_STATUS: rdata_next = status_word;
                default: rdata_next = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            f2_sel_reg <= RST_FAULT2_STOP;
            ot_sel_reg <= RST_OVERTRAVEL_STOP;
            f1_sel_reg <= RST_FAULT1_STOP;
            f2_act_reg <= RST_FAULT2_STOP;
            ot_act_reg <= RST_OVERTRAVEL_STOP;
            f1_act_reg <= RST_FAULT1_STOP;
            on_delay_reg <= RST_BRAKE_ON_DELAY;
            off_delay_reg <= RST_BRAKE_OFF_DELAY;
            speed_thr_reg <= RST_SPEED_THRESHOLD;
            soff_delay_reg <= RST_SERVO_OFF_DELAY;
            control_reg <= RST_CONTROL;
            rdata_reg <= 16'h0000;
        end else begin
            f2_sel_reg <= f2_sel_next;
            ot_sel_reg <= ot_sel_next;
            f1_sel_reg <= f1_sel_next;
            f2_act_reg <= f2_act_next;
            ot_act_reg <= ot_act_next;
            f1_act_reg <= f1_act_next;
            on_delay_reg <= on_delay_next;
            off_delay_reg <= off_delay_next;
            speed_thr_reg <= speed_thr_next;
            soff_delay_reg <= soff_delay_next;
            control_reg <= control_next;
            rdata_reg <= rdata_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // stop sequencer

    state_t state_reg, state_next;
    logic [15:0] count_reg, count_next;
    cause_t cause_reg, cause_next, cause_now;
    stop_plan_t plan_reg, plan_next, plan_now, ot_plan;
    logic power_reg, power_next, db_reg, db_next, brake_reg, brake_next, accept_reg, accept_next;
    logic count_done;

    assign count_done = (count_reg == 16'h0000);
    assign ot_plan = decode_stop(CAUSE_OVERTRAVEL, ot_act_reg, forced);

    // class-1 outranks class-2, which outranks overtravel and then servo-off
    always_comb begin
        cause_now = CAUSE_NONE;
        if (fault1_active) begin
            cause_now = CAUSE_FAULT1;
        end else if (fault2_active) begin
            cause_now = CAUSE_FAULT2;
        end else if (overtravel_active && ot_plan.active) begin
            cause_now = CAUSE_OVERTRAVEL;
        end else if (!servo_enable) begin
            cause_now = CAUSE_SERVO_OFF;
        end
        unique case (cause_now)
            CAUSE_FAULT1: plan_now = decode_stop(CAUSE_FAULT1, f1_act_reg, forced);
            CAUSE_FAULT2: plan_now = decode_stop(CAUSE_FAULT2, f2_act_reg, forced);
            CAUSE_OVERTRAVEL: plan_now = ot_plan;
            default: plan_now = decode_stop(cause_now, 16'h0000, forced);
        endcase
    end

    always_comb begin
        state_next = state_reg;
        count_next = (ms_tick.tick && !count_done) ? count_reg - 16'h0001 : count_reg;
        cause_next = cause_reg;
        plan_next = plan_reg;
        power_next = power_reg;
        db_next = db_reg;
        brake_next = brake_reg;
        accept_next = 1'b0;
        unique case (state_reg)
            ST_OFF: begin
                power_next = 1'b0;
                db_next = 1'b0;
                brake_next = 1'b0;
                if (cause_now == CAUSE_NONE) begin
                    state_next = ST_HOLD_REF;
                    power_next = 1'b1;
                    brake_next = 1'b1;
                    count_next = on_delay_reg;
                end
            end
            ST_HOLD_REF, ST_RUN: begin
                accept_next = (state_reg == ST_RUN) || count_done;
                if (state_reg == ST_HOLD_REF && count_done) state_next = ST_RUN;
                if (cause_now != CAUSE_NONE) begin
                    accept_next = 1'b0;
                    cause_next = cause_now;
                    plan_next = plan_now;
                    power_next = motor_at_standstill || !(plan_now.decel inside {DEC_COAST, DEC_DB});
                    db_next = !motor_at_standstill && (plan_now.decel == DEC_DB);
                    if (motor_at_standstill) begin
                        state_next = ST_BRAKE_WAIT;
                        brake_next = 1'b0;
                        count_next = off_delay_reg;
                    end else begin
                        state_next = ST_STOPPING;
                        count_next = soff_delay_reg;
                    end
                end
            end
            ST_STOPPING: begin
                if (count_done || motor_speed_rpm < speed_thr_reg) begin
                    brake_next = 1'b0;
                end
                if (motor_at_standstill && !brake_reg) begin
                    state_next = ST_STOPPED;
                end else if (motor_at_standstill) begin
                    state_next = ST_BRAKE_WAIT;
                    brake_next = 1'b0;
                    count_next = off_delay_reg;
                end
            end
            ST_BRAKE_WAIT: begin
                if (count_done) state_next = ST_STOPPED;
            end
            ST_STOPPED: begin
                // post-stop state holds until both faults clear and no overtravel with an active stop plan remains
                power_next = (plan_reg.post == POST_LOCK);
                db_next = (plan_reg.post == POST_DB);
                brake_next = 1'b0;
                if (!fault1_active && !fault2_active && !(overtravel_active && ot_plan.active)) begin
                    state_next = ST_OFF;
                    cause_next = CAUSE_NONE;
                end
            end
        endcase
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= ST_OFF;
            count_reg <= 16'h0000;
            cause_reg <= CAUSE_NONE;
            plan_reg <= '{1'b0, DEC_NONE, POST_DEENERGIZE};
            power_reg <= 1'b0;
            db_reg <= 1'b0;
            brake_reg <= 1'b0;
            accept_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            count_reg <= count_next;
            cause_reg <= cause_next;
            plan_reg <= plan_next;
            power_reg <= power_next;
            db_reg <= db_next;
            brake_reg <= brake_next;
            accept_reg <= accept_next;
        end
    end

    assign status_word = {5'h00, cause_reg, state_reg, accept_reg, brake_reg, db_reg, power_reg, forced};
    assign reg_rdata = rdata_reg;
    assign power_stage_enable = power_reg;
    assign dynamic_brake = db_reg;
    assign holding_brake_out = brake_reg;
    assign reference_accept = accept_reg;
    assign decel_mode = plan_reg.decel;
    assign post_state = plan_reg.post;
endmodule

// ==== verification/servo_stop_brake_sequencer_monitor.sv ====
// port assertions of the stop selector and brake sequencer
// assumes binding to the top module, one clock domain
`timescale 1ns/100ps
module servo_stop_brake_monitor
    import stop_brake_pkg::*;
(
    input wire logic clk,
    input wire logic reset_n,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic fault1_active,
    input wire logic fault2_active,
    input wire logic power_stage_enable,
    input wire logic dynamic_brake,
    input wire logic holding_brake_out,
    input wire logic reference_accept,
    input wire decel_t decel_mode,
    input wire post_t post_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);
    a_db_power_excl: assert property (dynamic_brake |-> !power_stage_enable)
        else $error("dynamic brake with power on");
    a_accept_brake_on: assert property (reference_accept |-> holding_brake_out && power_stage_enable)
        else $error("accept without brake and power");
    a_fault_drops_accept: assert property ((fault1_active || fault2_active) |-> ##2 !reference_accept)
        else $error("accept kept during fault");
    a_coast_no_db: assert property (decel_mode == DEC_COAST |-> !dynamic_brake)
        else $error("dynamic brake on coast");
    a_quick_no_db: assert property (decel_mode == DEC_RAMP_QUICK && post_state != POST_DB |-> !dynamic_brake)
        else $error("dynamic brake on quick ramp");
    a_rdata_pulse: assert property (reg_rdata != 16'h0000 |-> $past(reg_read))
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (reg_read && reg_addr > OFS_STATUS |=> reg_rdata == 16'h0000)
        else $error("unmapped read not zero");
    a_ctrl_readback: assert property ((reg_write && reg_addr == OFS_CONTROL) ##2 (reg_read && reg_addr == OFS_CONTROL)
        |=> reg_rdata == ($past(reg_wdata, 3) & CTL_WRITE_MASK))
        else $error("control readback wrong");
endmodule
bind servo_stop_brake_sequencer servo_stop_brake_monitor i_servo_stop_brake_monitor (.clk, .reset_n, .reg_addr,
    .reg_wdata, .reg_write, .reg_read, .reg_rdata, .fault1_active, .fault2_active, .power_stage_enable,
    .dynamic_brake, .holding_brake_out, .reference_accept, .decel_mode, .post_state);

// ==== verification/motor_model.sv ====
// behavioural motor: runs while driven, coasts down otherwise
// assumes the drive's control clock
`timescale 1ns/100ps
module motor_model (
    input wire logic clk,
    input wire logic power_stage_enable,
    input wire logic reference_accept,
    output logic [15:0] motor_speed_rpm,
    output logic motor_at_standstill
);
    // slow decay so the speed threshold is crossed well before standstill
    initial motor_speed_rpm = 16'h0000;
    always @(posedge clk) begin
        if (power_stage_enable && reference_accept) begin
            motor_speed_rpm <= 16'h00C8;
        end else begin
            motor_speed_rpm <= (motor_speed_rpm > 16'h0005) ? motor_speed_rpm - 16'h0005 : 16'h0000;
        end
    end
    assign motor_at_standstill = (motor_speed_rpm == 16'h0000);
endmodule

// ==== verification/servo_stop_brake_sequencer_tb_top.sv ====
// bench of the stop selector and brake sequencer
// assumes the motor model at the power stage side
`timescale 1ns/100ps
module servo_stop_brake_sequencer_tb_top;
    import stop_brake_pkg::*;
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fails++; $display("wrong value at %0t: %0h", $time, a); end end
`define WAITF(c) begin n = 0; while (!(c) && n < 300) begin @(posedge clk) #1; n++; end `CHK(c, 1'b1) end
    logic clk = 0, reset_n = 0, reg_write = 0, reg_read = 0, servo_enable = 0;
    logic fault1_active = 0, fault2_active = 0, overtravel_active = 0;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000, reg_rdata, motor_speed_rpm;
    logic motor_at_standstill, power_stage_enable, dynamic_brake, holding_brake_out, reference_accept;
    decel_t decel_mode;
    post_t post_state;
    int fails = 0, total_checks = 0, n, cyc = 0;
    logic [15:0] rst_tab [8] = '{RST_FAULT2_STOP, RST_OVERTRAVEL_STOP, RST_FAULT1_STOP, RST_BRAKE_ON_DELAY,
        RST_BRAKE_OFF_DELAY, RST_SPEED_THRESHOLD, RST_SERVO_OFF_DELAY, RST_CONTROL};
    decel_t f2d [9] = '{DEC_ZERO_SPEED, DEC_ETORQUE, DEC_RAMP_QUICK, DEC_RAMP_PROFILE, DEC_DB, DEC_COAST,
        DEC_RAMP_PROFILE, DEC_RAMP_QUICK, DEC_ETORQUE};
    decel_t otd [7] = '{DEC_COAST, DEC_ZERO_SPEED, DEC_ZERO_SPEED, DEC_RAMP_QUICK, DEC_RAMP_QUICK, DEC_DB, DEC_DB};
    post_t otp [7] = '{POST_DEENERGIZE, POST_LOCK, POST_DEENERGIZE, POST_DEENERGIZE, POST_LOCK, POST_DEENERGIZE, POST_DB};
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 8000) begin
            fails++;
            report_and_stop();
        end
    end
    // a 4-cycle ms tick shortens the delays, though the reset brake-off delay still spans about 600 cycles
    servo_stop_brake_sequencer #(.MS_CYCLES(4)) i_servo_stop_brake_sequencer (.clk, .reset_n, .reg_addr, .reg_wdata,
        .reg_write, .reg_read, .reg_rdata, .servo_enable, .fault1_active, .fault2_active, .overtravel_active,
        .motor_at_standstill, .motor_speed_rpm, .power_stage_enable, .dynamic_brake, .holding_brake_out,
        .reference_accept, .decel_mode, .post_state);
    motor_model i_motor_model (.clk, .power_stage_enable, .reference_accept, .motor_speed_rpm, .motor_at_standstill);
    ////////////////////////////////////////////////////////////////
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1 `CHK(reg_rdata, exp)
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic run_stop(input logic [2:0] c, input logic [3:0] a, input logic [15:0] code, input logic [15:0] ctl,
            input bit late, input decel_t d, input post_t p);
        if (!late) wr(a, code);
        wr(OFS_CONTROL, ctl);
        `WAITF(reference_accept === 1'b1)
        repeat (4) @(posedge clk);
        if (late) wr(a, code);
        if (late) rd(a, code);
        @(posedge clk);
        {overtravel_active, fault2_active, fault1_active} <= c;
        repeat (2) @(posedge clk);
        #1 `CHK(decel_mode, d)
        `CHK(post_state, p)
        `CHK(holding_brake_out, 1'b1)
        `WAITF(motor_at_standstill === 1'b1)
        repeat (3) @(posedge clk);
        #1 `CHK(power_stage_enable, p == POST_LOCK)
        `CHK(dynamic_brake, p == POST_DB)
        `CHK(holding_brake_out, 1'b0)
        @(posedge clk);
        {overtravel_active, fault2_active, fault1_active} <= 3'b000;
        $display("stop test done, code %0h", code);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (int i = 0; i < 8; i++) rd(i[3:0], rst_tab[i]);
        rd(4'h9, 16'h0000);
        wr(OFS_FAULT2_STOP, 16'h0004);
        rd(OFS_FAULT2_STOP, RST_FAULT2_STOP);
        wr(OFS_FAULT1_STOP, 16'h0003);
        rd(OFS_FAULT1_STOP, RST_FAULT1_STOP);
        wr(OFS_CONTROL, 16'hFFFF);
        rd(OFS_CONTROL, CTL_WRITE_MASK);
        wr(OFS_BRAKE_ON_DELAY, 16'h0002);
        wr(OFS_FAULT1_STOP, 16'h0000);
        $display("register test done");
        @(posedge clk);
        servo_enable <= 1'b1;
        `WAITF(holding_brake_out === 1'b1)
        `CHK(reference_accept, 1'b0)
        `WAITF(reference_accept === 1'b1)
        `CHK(n >= 3 && n <= 10, 1'b1)
        run_stop(3'b001, OFS_FAULT1_STOP, 16'h0000, 16'h0000, 0, DEC_COAST, POST_DEENERGIZE);
        run_stop(3'b001, OFS_FAULT1_STOP, 16'h0001, 16'h0000, 0, DEC_DB, POST_DEENERGIZE);
        run_stop(3'b001, OFS_FAULT1_STOP, 16'h0000, 16'h0000, 1, DEC_DB, POST_DEENERGIZE);
        run_stop(3'b001, OFS_FAULT1_STOP, 16'h0002, 16'h0000, 0, DEC_DB, POST_DB);
        run_stop(3'b001, OFS_FAULT1_STOP, 16'h0000, 16'h0001, 0, DEC_DB, POST_DB);
        for (int k = -5; k <= 3; k++) run_stop(3'b010, OFS_FAULT2_STOP, 16'(k), 16'h0000, 0, f2d[k + 5],
            k < 0 ? POST_DB : POST_DEENERGIZE);
        run_stop(3'b010, OFS_FAULT2_STOP, 16'hFFFB, 16'h0001, 0, DEC_RAMP_QUICK, POST_DEENERGIZE);
        for (int k = 0; k < 7; k++) run_stop(3'b100, OFS_OVERTRAVEL_STOP, 16'(k), 16'h0000, 0, otd[k], otp[k]);
        run_stop(3'b100, OFS_OVERTRAVEL_STOP, 16'h0007, 16'h0001, 0, DEC_RAMP_QUICK, POST_LOCK);
        wr(OFS_CONTROL, 16'h0000);
        `WAITF(holding_brake_out === 1'b1)
        @(posedge clk);
        fault1_active <= 1'b1;
        repeat (2) @(posedge clk);
        #1 `CHK(power_stage_enable, 1'b1)
        `CHK(holding_brake_out, 1'b0)
        repeat (590) @(posedge clk);
        #1 `CHK(power_stage_enable, 1'b1)
        `WAITF(power_stage_enable === 1'b0)
        $display("standstill brake test done");
        report_and_stop();
    end
endmodule
